// [rtl/resonant_pwm_timing.sv]
`timescale 1ns/1ps
`include "resonant_pwm_consts.svh"

module resonant_pwm_timing
    import resonant_pwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic sense_low,
    output logic [7:0] reg_rdata,
    output logic primary_drive_first,
    output logic resonant_active
);
    localparam logic [11:0] UNITS = 12'(`UNITS_PER_CLK);

    timing_state_t q;
    timing_state_t d;
    logic sample_tick;
    logic resonant_req;
    logic [11:0] limit;
    logic [11:0] half_cycle_point;
    logic [12:0] t_adv;
    logic [13:0] fall_point;
    logic rise_in_first_half;

    function automatic logic [11:0] clamp_period(input logic [11:0] v, input logic [11:0] lim);
        logic [11:0] r;
        r = (v < `PERIOD_FLOOR) ? `PERIOD_FLOOR : v;
        if (r > lim) begin
            r = lim;
        end
        return r;
    endfunction

    sample_tick_gen u_tick (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sample_tick(sample_tick)
    );

    assign resonant_req = (q.freq_sel[5:0] == `RESONANT_CODE);
    assign limit = {q.max_hi, q.max_lo[7:4]};
    assign half_cycle_point = {1'b0, q.period[11:1]};
    assign t_adv = {1'b0, q.t} + {1'b0, UNITS};
    // Sign-extended offset: codes with bit 7 set land before the half point
    assign fall_point = {2'b00, half_cycle_point} + {{6{q.fall_offset[7]}}, q.fall_offset};
    assign rise_in_first_half = ({4'h0, q.rise_delay} < half_cycle_point);

    always_comb begin
        d = q;
        d.rdata = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                `OFS_FREQ_SELECT: d.freq_sel = reg_wdata;
                `OFS_RISE_DELAY: d.rise_delay = reg_wdata;
                `OFS_MAX_PERIOD_HI: d.max_hi = reg_wdata;
                `OFS_FALL_OFFSET: d.fall_offset = reg_wdata;
                `OFS_MAX_PERIOD_LO: d.max_lo = reg_wdata;
                default: d.freq_sel = q.freq_sel;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `OFS_FREQ_SELECT: d.rdata = q.freq_sel;
                `OFS_RISE_DELAY: d.rdata = q.rise_delay;
                `OFS_MAX_PERIOD_HI: d.rdata = q.max_hi;
                `OFS_FALL_OFFSET: d.rdata = q.fall_offset;
                `OFS_MAX_PERIOD_LO: d.rdata = q.max_lo;
                `OFS_STATUS_PERIOD_HI: d.rdata = q.period[11:4];
                `OFS_STATUS_PERIOD_LO: d.rdata = {q.period[3:0], 3'b000, q.active};
                default: d.rdata = 8'h00;
            endcase
        end
        // Loop integrator: step the period at the fixed sampling rate
        if (sample_tick) begin
            if (sense_low) begin
                // Saturate first so a full-scale limit cannot wrap round to the floor
                d.period_cmd = (q.period_cmd == 12'hfff) ? q.period_cmd : q.period_cmd + 12'h001;
                d.period_cmd = clamp_period(d.period_cmd, limit);
            end else begin
                d.period_cmd = clamp_period(q.period_cmd - 12'h001, limit);
            end
        end
        case (q.mode)
            MODE_IDLE: begin
                d.drive = 1'b0;
                d.active = 1'b0;
                d.t = 12'h000;
                if (resonant_req) begin
                    d.mode = MODE_RUN;
                    d.active = 1'b1;
                    d.period = clamp_period(q.period_cmd, limit);
                end
            end
            MODE_RUN: begin
                if (!resonant_req) begin
                    d.mode = MODE_IDLE;
                    d.drive = 1'b0;
                    d.active = 1'b0;
                    d.t = 12'h000;
                end else begin
                    // Period only changes at a cycle boundary so each cycle keeps its duty
                    if (t_adv >= {1'b0, q.period}) begin
                        d.t = 12'h000;
                        d.period = clamp_period(q.period_cmd, limit);
                    end else begin
                        d.t = t_adv[11:0];
                    end
                    d.drive = rise_in_first_half && (q.t >= {4'h0, q.rise_delay})
                        && !fall_point[13] && ({2'b00, q.t} < fall_point);
                end
            end
            default: begin
                d.mode = MODE_IDLE;
                d.drive = 1'b0;
                d.active = 1'b0;
                d.t = 12'h000;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{freq_sel: `REG_RESET, rise_delay: `REG_RESET, max_hi: `REG_RESET,
                   fall_offset: `REG_RESET, max_lo: `REG_RESET, t: 12'h000,
                   period: `PERIOD_FLOOR, period_cmd: `PERIOD_FLOOR, drive: 1'b0,
                   active: 1'b0, rdata: 8'h00, mode: MODE_IDLE};
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign primary_drive_first = q.drive;
    assign resonant_active = q.active;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence seq_running;
        q.mode == MODE_RUN && resonant_req && !reg_wr;
    endsequence

    sequence seq_tick_low;
        sample_tick && sense_low && (q.period_cmd < limit) && (q.period_cmd >= `PERIOD_FLOOR);
    endsequence

    sequence seq_wrap;
        t_adv >= {1'b0, q.period};
    endsequence

    sequence seq_trailing;
        q.drive && !$past(q.fall_offset[7]);
    endsequence

    chk_mode_enable: assert property (resonant_req |=> q.mode == MODE_RUN)
        else $error("resonant code did not start resonant mode");
    chk_mode_leave: assert property (!resonant_req |=> q.mode == MODE_IDLE ##1 !q.drive)
        else $error("drive left running outside resonant mode");
    chk_rise_delay: assert property ($rose(q.drive) |-> $past(q.t) >= {4'h0, $past(q.rise_delay)})
        else $error("drive rose before rise delay");
    chk_limit_clamp: assert property (sample_tick && limit >= `PERIOD_FLOOR |=> q.period_cmd <= $past(limit))
        else $error("period command above maximum limit");
    chk_cycle_wrap: assert property (seq_running ##0 (t_adv >= {1'b0, q.period}) |=> q.t == 12'h000)
        else $error("cycle did not end at period");
    chk_fall_point: assert property (q.drive |-> !$past(fall_point[13]) && {2'b00, $past(q.t)} < $past(fall_point))
        else $error("drive high past falling point");
    chk_fall_early: assert property (q.drive && $past(q.fall_offset[7]) |-> $past(q.t) < $past(half_cycle_point))
        else $error("leading offset let drive pass half point");
    chk_first_half: assert property (q.drive |-> $past(q.rise_delay) < $past(half_cycle_point[7:0])
        || $past(half_cycle_point[11:8]) != 4'h0)
        else $error("drive pulse started outside first half");
    chk_fixed_duty: assert property (seq_running ##1 (q.t != 12'h000) |-> $stable(q.period))
        else $error("period changed inside a cycle");
    chk_slow_down: assert property (seq_tick_low |=> q.period_cmd == $past(q.period_cmd) + 12'h001)
        else $error("low sense did not lengthen the period");

    // Mode flag and idle state
    chk_idle_quiet: assert property (q.mode == MODE_IDLE |-> !q.drive)
        else $error("drive high while idle");
    chk_active_flag: assert property (resonant_active == (q.mode == MODE_RUN))
        else $error("active flag disagrees with mode");
    chk_mode_code: assert property (q.mode == MODE_RUN |-> $past(q.freq_sel[5:0]) == `RESONANT_CODE)
        else $error("running without the resonant code");
    chk_idle_counter: assert property (q.mode == MODE_IDLE |-> q.t == 12'h000)
        else $error("cycle counter moving while idle");

    // Register writes feed the edge and limit settings, and the rise delay reads back
    chk_rise_store: assert property (reg_wr && reg_addr == `OFS_RISE_DELAY |=> q.rise_delay == $past(reg_wdata))
        else $error("rise delay write lost");
    chk_read_rise: assert property (reg_rd && reg_addr == `OFS_RISE_DELAY |=> reg_rdata == $past(q.rise_delay))
        else $error("rise delay read back wrong");
    chk_limit_high: assert property (reg_wr && reg_addr == `OFS_MAX_PERIOD_HI |=> limit[11:4] == $past(reg_wdata))
        else $error("limit upper bits not from high register");
    chk_limit_write: assert property (reg_wr && reg_addr == `OFS_MAX_PERIOD_LO |=> limit[3:0] == $past(reg_wdata[7:4]))
        else $error("limit lower bits not from companion register");
    chk_fall_store: assert property (reg_wr && reg_addr == `OFS_FALL_OFFSET |=> q.fall_offset == $past(reg_wdata))
        else $error("fall offset write lost");

    // Period limit, falling point and sampling rate
    chk_period_load: assert property (seq_running ##0 seq_wrap |=> q.period <= $past(limit))
        else $error("loaded period above maximum limit");
    chk_late_fall: assert property (seq_trailing |-> {2'b00, $past(q.t)} <
        {2'b00, $past(half_cycle_point)} + {6'h00, $past(q.fall_offset)})
        else $error("trailing fall placed too late");
    chk_negative_fall: assert property (q.mode == MODE_RUN && fall_point[13] |=> !q.drive)
        else $error("pulse driven with fall before cycle start");
    chk_sample_rate: assert property (sample_tick |-> ##250 sample_tick)
        else $error("feedback sampling rate not fixed");

endmodule

// [rtl/resonant_pwm_consts.svh]
`ifndef RESONANT_PWM_CONSTS_SVH
`define RESONANT_PWM_CONSTS_SVH

// Register offsets
`define OFS_FREQ_SELECT 8'h40
`define OFS_RISE_DELAY 8'h41
`define OFS_MAX_PERIOD_HI 8'h42
`define OFS_FALL_OFFSET 8'h43
`define OFS_MAX_PERIOD_LO 8'h44
`define OFS_STATUS_PERIOD_HI 8'h70
`define OFS_STATUS_PERIOD_LO 8'h71

// Field layout and reset values
`define RESONANT_CODE 6'h3f
`define REG_RESET 8'h00
`define PERIOD_FLOOR 12'h002

// Timing
`define CLK_PERIOD_NS 10
`define STEP_NS 5
`define UNITS_PER_CLK (`CLK_PERIOD_NS / `STEP_NS)
`define CLK_KHZ 100000
`define FB_SAMPLE_KHZ 400
`define FB_SAMPLE_CYCLES (`CLK_KHZ / `FB_SAMPLE_KHZ)

`endif

// [rtl/resonant_pwm_pkg.sv]
package resonant_pwm_pkg;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b01,
        MODE_RUN = 2'b10
    } mode_t;

    typedef struct packed {
        logic [7:0] freq_sel;
        logic [7:0] rise_delay;
        logic [7:0] max_hi;
        logic [7:0] fall_offset;
        logic [7:0] max_lo;
        logic [11:0] t;
        logic [11:0] period;
        logic [11:0] period_cmd;
        logic drive;
        logic active;
        logic [7:0] rdata;
        mode_t mode;
    } timing_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } divider_state_t;

endpackage

// [rtl/sample_tick_gen.sv]
`timescale 1ns/1ps
`include "resonant_pwm_consts.svh"

// Fixed-rate feedback sampling strobe, independent of the switching period
module sample_tick_gen
    import resonant_pwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    output logic sample_tick
);
    localparam logic [7:0] LAST = 8'((`FB_SAMPLE_CYCLES) - 1);

    divider_state_t q;
    divider_state_t d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.count == LAST) begin
            d.count = 8'h00;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sample_tick = q.tick;

endmodule

// [tb/drive_stage_model.sv]
`timescale 1ns/1ps
// Switch driver stand-in: measures pulse width and rise-to-rise spacing in clocks
module drive_stage_model(
    input wire logic clk_sys,
    input wire logic drive_in,
    output int high_len = 0,
    output int rise_gap = 0
);
    int hc = 0;
    int gc = 0;
    logic last = 1'b0;
    always @(posedge clk_sys) begin
        last <= drive_in;
        gc <= (drive_in && !last) ? 1 : gc + 1;
        hc <= (drive_in && !last) ? 1 : hc + 1;
        if (drive_in && !last) rise_gap <= gc;
        if (!drive_in && last) high_len <= hc;
    end
endmodule

// [tb/resonant_pwm_timing_bench.sv]
`timescale 1ns/1ps
module resonant_pwm_timing_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sense_low = 1'b1;
    logic [7:0] reg_rdata;
    logic primary_drive_first;
    logic resonant_active;
    logic seen;
    int high_len;
    int rise_gap;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] rise_tab [4] = '{8'h0a, 8'h0a, 8'h0a, 8'h0b};
    logic [7:0] fall_tab [4] = '{8'h05, 8'hfb, 8'h7f, 8'h00};
    logic [15:0] len_tab [4] = '{16'h0017, 16'h0012, 16'h002d, 16'h0013};

    resonant_pwm_timing uut(.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .sense_low(sense_low), .reg_rdata(reg_rdata),
        .primary_drive_first(primary_drive_first), .resonant_active(resonant_active));
    drive_stage_model stage(.clk_sys(clk_sys), .drive_in(primary_drive_first), .high_len(high_len),
        .rise_gap(rise_gap));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task close_out;
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #600000;
        mismatches++;
        close_out();
    end

    initial begin
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        rd(8'h71, 8'h20);
        wr(8'h41, 8'h0a);
        wr(8'h42, 8'h06);
        wr(8'h44, 8'h4c);
        wr(8'h45, 8'h99);
        wr(8'h70, 8'hff);
        rd(8'h41, 8'h0a);
        rd(8'h44, 8'h4c);
        rd(8'h45, 8'h00);
        rd(8'h70, 8'h00);
        wr(8'h40, 8'hff);
        repeat (2) @(negedge clk_sys);
        chk(resonant_active, 1'b1);
        wr(8'h40, 8'h3e);
        repeat (2) @(negedge clk_sys);
        chk(resonant_active, 1'b0);
        wr(8'h40, 8'h3f);
        repeat (25000) @(negedge clk_sys);
        rd(8'h70, 8'h06);
        rd(8'h71, 8'h41);
        for (int i = 0; i < 4; i++) begin
            wr(8'h41, rise_tab[i]);
            wr(8'h43, fall_tab[i]);
            repeat (200) @(negedge clk_sys);
            chk(high_len[15:0], len_tab[i]);
            chk(rise_gap[15:0], 16'h0032);
        end
        wr(8'h43, 8'h80);
        seen = 1'b0;
        repeat (200) @(negedge clk_sys) seen |= primary_drive_first;
        chk(seen, 1'b0);
        wr(8'h43, 8'h00);
        sense_low = 1'b0;
        repeat (1000) @(negedge clk_sys);
        chk(rise_gap < 50, 1'b1);
        sense_low = 1'b1;
        wr(8'h42, 8'h03);
        wr(8'h44, 8'h20);
        repeat (600) @(negedge clk_sys);
        rd(8'h70, 8'h03);
        rd(8'h71, 8'h21);
        chk(rise_gap[15:0], 16'h0019);
        chk(high_len[15:0], 16'h0007);
        wr(8'h40, 8'h00);
        seen = 1'b0;
        repeat (100) @(negedge clk_sys) seen |= primary_drive_first | resonant_active;
        chk(seen, 1'b0);
        close_out();
    end
endmodule
